// ### logic/rdag_decoder.sv
module rdag_decoder import rdag_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] fetch_word,
  input wire logic [31:0] fetch_pc,
  input wire logic fetch_valid,
  output logic fetch_ready,
  input wire logic [31:0] base_data,
  output rdag_dec_t dec,
  output rdag_agen_t agen
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic ready;
    logic hold_valid;
    logic second;
    logic [31:0] hold_word;
    logic [31:0] hold_pc;
    rdag_dec_t dec;
  } rdag_dec_state_t;

  rdag_dec_state_t st;
  rdag_dec_state_t next_st;

  // Sign-extend helper for displacements and immediates.
  function automatic logic [31:0] sext(input logic [31:0] v, input int bits);
    logic [31:0] m;
    m = 32'h0000_0001 << (bits - 1);
    return (v ^ m) - m;
  endfunction

  // Class of a valid opcode follows from its group range.
  function automatic rdag_class_t class_of(input logic [6:0] op);
    rdag_class_t c;
    c = RDAG_CL_NONE;
    if (op >= OP_COUNT) c = RDAG_CL_NONE;
    else if (op >= OP_DSP_BASE) c = RDAG_CL_DSP;
    else if (op >= OP_TRAP) c = RDAG_CL_EXC;
    else if (op >= OP_BRANCH_BASE) c = RDAG_CL_BRANCH;
    else if (op >= OP_SHIFT_BASE) c = RDAG_CL_SHIFT;
    else if (op >= OP_MULDIV_BASE) c = RDAG_CL_MULDIV;
    else if (op >= OP_LOGIC_BASE) c = RDAG_CL_LOGIC;
    else if (op >= OP_ARITH_BASE) c = RDAG_CL_ARITH;
    else if (op >= OP_CMP_BASE) c = RDAG_CL_COMPARE;
    else if (op >= OP_LOAD_IMM24) c = RDAG_CL_TRANSFER;
    else c = RDAG_CL_LOADSTORE;
    return c;
  endfunction

  logic [31:0] cur;
  logic is32;
  logic [6:0] raw_op;
  logic [3:0] ra;
  logic [3:0] rb;
  logic [15:0] imm16;
  logic only32;
  logic long_branch;
  rdag_dec_t d;

  // Pick the instruction under decode: whole word, high half, or low half.
  always_comb begin
    cur = st.hold_word;
    is32 = !st.second && st.hold_word[WORD_W - 1];
    if (!is32) begin
      cur = st.second ? {st.hold_word[HALF_W - 1:0], 16'h0000}
                      : {st.hold_word[WORD_W - 1:HALF_W], 16'h0000};
    end
    raw_op = cur[OP_MSB + HALF_W:OP_LSB + HALF_W];
    ra = cur[RA_MSB + HALF_W:RA_LSB + HALF_W];
    rb = cur[RB_MSB + HALF_W:RB_LSB + HALF_W];
    imm16 = cur[HALF_W - 1:0];
    only32 = raw_op inside {OP_LOAD_IMM24, OP_SET_HIGH, OP_ADD3, OP_ADD_OVF3, OP_AND3,
                            OP_OR3, OP_XOR3, OP_SHL3, OP_SHRA3, OP_SHRL3};
    long_branch = raw_op inside {OP_BR_CARRY, OP_BR_LINK, OP_BR_NCARRY, OP_BR_ALWAYS};
  end

  // Field decode of the selected instruction.
  always_comb begin
    d = '0;
    d.valid = st.hold_valid;
    d.pc = {st.hold_pc[31:2], 2'b00};
    d.op = raw_op;
    d.base = rb;
    d.width = RDAG_W_WORD;
    d.dst = '{is_ctrl: 1'b0, idx: ra};
    d.src = '{is_ctrl: 1'b0, idx: rb};
    // Auto-update forms exist only as 16-bit encodings and fold onto word load/store.
    if (!is32 && raw_op inside {OP_LOAD_POSTINC, OP_STORE_PREINC, OP_STORE_PREDEC}) begin
      d.op = (raw_op == OP_LOAD_POSTINC) ? OP_LOAD_WORD : OP_STORE_WORD;
      d.amode = (raw_op == OP_LOAD_POSTINC) ? RDAG_AM_POSTINC :
                (raw_op == OP_STORE_PREINC) ? RDAG_AM_PREINC : RDAG_AM_PREDEC;
    end
    d.iclass = class_of(d.op);
    // Unknown codes, 32-bit-only ops in short form, or a long word in the low half.
    d.reserved = (d.iclass == RDAG_CL_NONE) || (!is32 && only32) ||
                 (st.second && st.hold_word[FMT_BIT]);
    case (d.iclass)
      RDAG_CL_LOADSTORE: begin
        // Memory traffic only; no register-to-register result.
        if (d.amode == RDAG_AM_NONE) begin
          d.amode = is32 ? RDAG_AM_RELATIVE : RDAG_AM_INDIRECT;
        end
        if (is32) begin
          d.imm_kind = RDAG_IMM16;
          d.imm = sext({16'h0000, imm16}, 16);
        end
        d.mem_write = d.op >= OP_STORE_WORD;
        d.width = d.op inside {OP_LOAD_BYTE, OP_LOAD_UBYTE, OP_STORE_BYTE} ? RDAG_W_BYTE :
                  d.op inside {OP_LOAD_HALF, OP_LOAD_UHALF, OP_STORE_HALF} ? RDAG_W_HALF :
                  RDAG_W_WORD;
        d.mem_signed = d.op inside {OP_LOAD_BYTE, OP_LOAD_HALF};
      end
      RDAG_CL_TRANSFER: begin
        // No address mode is set; no memory access follows, as only the load/store class raises one.
        d.amode = RDAG_AM_NONE;
        if (d.op == OP_MOVE_FROM_CTRL) d.src.is_ctrl = 1'b1;
        if (d.op == OP_MOVE_TO_CTRL) d.dst.is_ctrl = 1'b1;
        if (d.op == OP_LOAD_IMM24) begin
          d.imm_kind = RDAG_IMM24;
          d.imm = {8'h00, cur[23:0]};
        end else if (d.op == OP_SET_HIGH) begin
          d.imm_kind = RDAG_IMM16;
          d.imm = {imm16, 16'h0000};
        end else if (d.op == OP_LOAD_IMM) begin
          d.imm_kind = is32 ? RDAG_IMM16 : RDAG_IMM8;
          d.imm = is32 ? sext({16'h0000, imm16}, 16)
                       : sext({24'h000000, ra, rb}, 8);
        end
      end
      RDAG_CL_BRANCH: begin
        // Register jumps take their target from rb and the no-op has none; the rest are PC relative.
        if (!(d.op inside {OP_JUMP_LINK, OP_JUMP, OP_NO_OP})) begin
          d.amode = RDAG_AM_PCREL;
          if (!is32) begin
            d.imm_kind = RDAG_IMM8;
            d.imm = sext({24'h000000, ra, rb}, 8);
          end else if (long_branch) begin
            d.imm_kind = RDAG_IMM24;
            d.imm = sext({8'h00, cur[23:0]}, 24);
          end else begin
            d.imm_kind = RDAG_IMM16;
            d.imm = sext({16'h0000, imm16}, 16);
          end
        end
      end
      RDAG_CL_EXC: begin
        // Both hand control to the exception unit instead of the branch path.
        d.trap = d.op == OP_TRAP;
        d.exc_return = d.op == OP_EXC_RETURN;
        if (d.trap) begin
          d.imm_kind = RDAG_IMM4;
          d.imm = {28'h0000000, rb};
        end
      end
      RDAG_CL_DSP: begin
        // The accumulator is implied; rounds write register 0, every other DSP op writes ra.
        d.dst.idx = (d.op >= OP_ACCUM_ROUND) ? 4'h0 : ra;
      end
      default: begin
        // Operate classes: immediates for the immediate and 3-operand forms.
        d.ovf_check = d.op inside {OP_ADD_OVF, OP_ADD_OVF3, OP_SUB_OVF};
        d.carry_use = d.op inside {OP_ADD_CARRY, OP_SUB_BORROW};
        if (d.op inside {OP_SHL_IMM, OP_SHRA_IMM, OP_SHRL_IMM}) begin
          d.imm_kind = RDAG_IMM5;
          d.imm = {27'h0, cur[20:16]};
        end else if (is32) begin
          d.imm_kind = RDAG_IMM16;
          d.imm = d.op inside {OP_AND3, OP_OR3, OP_XOR3} ? {16'h0000, imm16}
                                                        : sext({16'h0000, imm16}, 16);
        end else if (d.op inside {OP_ADD_IMM, OP_COMPARE_IMM}) begin
          d.imm_kind = RDAG_IMM8;
          d.imm = sext({24'h000000, ra, rb}, 8);
        end
      end
    endcase
    // A reserved slot still reports but carries no effect downstream.
    if (d.reserved) begin
      d.amode = RDAG_AM_NONE;
      d.trap = 1'b0;
      d.exc_return = 1'b0;
    end
  end

  // Sequencing of the held word: one slot for 32-bit, two for a packed pair.
  always_comb begin
    next_st = st;
    next_st.dec = d;
    if (st.hold_valid) begin
      if (is32 || st.second) begin
        next_st.hold_valid = 1'b0;
        next_st.second = 1'b0;
      end else begin
        next_st.second = 1'b1;
      end
    end else if (fetch_valid && st.ready) begin
      next_st.hold_valid = 1'b1;
      next_st.hold_word = fetch_word;
      next_st.hold_pc = fetch_pc;
    end
    // The next word is taken only once the held one is fully decoded.
    next_st.ready = !next_st.hold_valid;
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fetch_ready = st.ready;
  assign dec = st.dec;

  // Address generation runs one stage behind decode.
  rdag_addr_gen u_addr_gen (
    .clk(clk),
    .rst_b(rst_b),
    .dec(st.dec),
    .base_data(base_data),
    .agen(agen)
  );

endmodule

// ### logic/rdag_pkg.sv
package rdag_pkg;
  timeunit 1ns;
  timeprecision 1ps;

  // Instruction word layout. A clear top bit marks a 16-bit instruction.
  localparam int FMT_BIT = 15;
  localparam int OP_MSB = 14;
  localparam int OP_LSB = 8;
  localparam int RA_MSB = 7;
  localparam int RA_LSB = 4;
  localparam int RB_MSB = 3;
  localparam int RB_LSB = 0;
  localparam int HALF_W = 16;
  localparam int WORD_W = 32;

  // Number of distinct instructions; every other opcode is reserved, bar the 16-bit auto-update forms.
  localparam logic [6:0] OP_COUNT = 7'h53;

  // Load/store group, codes 0 to 9.
  localparam logic [6:0] OP_LOAD_WORD = 7'h00;
  localparam logic [6:0] OP_LOAD_BYTE = 7'h01;
  localparam logic [6:0] OP_LOAD_UBYTE = 7'h02;
  localparam logic [6:0] OP_LOAD_HALF = 7'h03;
  localparam logic [6:0] OP_LOAD_UHALF = 7'h04;
  localparam logic [6:0] OP_LOAD_LOCKED = 7'h05;
  localparam logic [6:0] OP_STORE_WORD = 7'h06;
  localparam logic [6:0] OP_STORE_BYTE = 7'h07;
  localparam logic [6:0] OP_STORE_HALF = 7'h08;
  localparam logic [6:0] OP_STORE_UNLOCK = 7'h09;
  // Transfer group.
  localparam logic [6:0] OP_LOAD_IMM24 = 7'h0A;
  localparam logic [6:0] OP_LOAD_IMM = 7'h0B;
  localparam logic [6:0] OP_MOVE_FROM_CTRL = 7'h0D;
  localparam logic [6:0] OP_MOVE_TO_CTRL = 7'h0E;
  localparam logic [6:0] OP_SET_HIGH = 7'h0F;
  // Remaining groups: the first code of each class, then the codes named within it.
  localparam logic [6:0] OP_CMP_BASE = 7'h10;
  localparam logic [6:0] OP_COMPARE_IMM = 7'h11;
  localparam logic [6:0] OP_ARITH_BASE = 7'h14;
  localparam logic [6:0] OP_ADD3 = 7'h15;
  localparam logic [6:0] OP_ADD_IMM = 7'h16;
  localparam logic [6:0] OP_ADD_OVF = 7'h17;
  localparam logic [6:0] OP_ADD_OVF3 = 7'h18;
  localparam logic [6:0] OP_ADD_CARRY = 7'h19;
  localparam logic [6:0] OP_SUB_OVF = 7'h1C;
  localparam logic [6:0] OP_SUB_BORROW = 7'h1D;
  localparam logic [6:0] OP_LOGIC_BASE = 7'h1E;
  localparam logic [6:0] OP_AND3 = 7'h1F;
  localparam logic [6:0] OP_OR3 = 7'h22;
  localparam logic [6:0] OP_XOR3 = 7'h24;
  localparam logic [6:0] OP_MULDIV_BASE = 7'h25;
  localparam logic [6:0] OP_SHIFT_BASE = 7'h2A;
  localparam logic [6:0] OP_SHL3 = 7'h2B;
  localparam logic [6:0] OP_SHL_IMM = 7'h2C;
  localparam logic [6:0] OP_SHRA3 = 7'h2E;
  localparam logic [6:0] OP_SHRA_IMM = 7'h2F;
  localparam logic [6:0] OP_SHRL3 = 7'h31;
  localparam logic [6:0] OP_SHRL_IMM = 7'h32;
  localparam logic [6:0] OP_BRANCH_BASE = 7'h33;
  localparam logic [6:0] OP_BR_CARRY = 7'h33;
  localparam logic [6:0] OP_BR_LINK = 7'h38;
  localparam logic [6:0] OP_BR_NCARRY = 7'h3B;
  localparam logic [6:0] OP_BR_ALWAYS = 7'h3E;
  localparam logic [6:0] OP_JUMP_LINK = 7'h3F;
  localparam logic [6:0] OP_JUMP = 7'h40;
  localparam logic [6:0] OP_NO_OP = 7'h41;
  localparam logic [6:0] OP_TRAP = 7'h42;
  localparam logic [6:0] OP_EXC_RETURN = 7'h43;
  localparam logic [6:0] OP_DSP_BASE = 7'h44;
  localparam logic [6:0] OP_ACCUM_ROUND = 7'h51;
  localparam logic [6:0] OP_ACCUM_ROUND_HALF = 7'h52;
  // Auto-update encodings, 16-bit form only; they decode to word load or store.
  localparam logic [6:0] OP_LOAD_POSTINC = 7'h70;
  localparam logic [6:0] OP_STORE_PREINC = 7'h71;
  localparam logic [6:0] OP_STORE_PREDEC = 7'h72;

  // Step applied to the base register by the auto-update modes.
  localparam logic [31:0] UPDATE_STEP = 32'h0000_0004;
  localparam int PCREL_SHIFT = 2;

  typedef enum logic [3:0] {
    RDAG_CL_NONE, RDAG_CL_LOADSTORE, RDAG_CL_TRANSFER, RDAG_CL_COMPARE, RDAG_CL_ARITH,
    RDAG_CL_LOGIC, RDAG_CL_MULDIV, RDAG_CL_SHIFT, RDAG_CL_BRANCH, RDAG_CL_EXC, RDAG_CL_DSP
  } rdag_class_t;

  typedef enum logic [2:0] {
    RDAG_AM_NONE, RDAG_AM_INDIRECT, RDAG_AM_RELATIVE, RDAG_AM_POSTINC,
    RDAG_AM_PREINC, RDAG_AM_PREDEC, RDAG_AM_PCREL
  } rdag_amode_t;

  typedef enum logic [2:0] {
    RDAG_IMM_NONE, RDAG_IMM4, RDAG_IMM5, RDAG_IMM8, RDAG_IMM16, RDAG_IMM24
  } rdag_imm_t;

  typedef enum logic [1:0] {RDAG_W_BYTE, RDAG_W_HALF, RDAG_W_WORD} rdag_width_t;

  typedef struct packed {
    logic is_ctrl;
    logic [3:0] idx;
  } rdag_rsel_t;

  typedef struct packed {
    logic valid;
    logic [6:0] op;
    rdag_class_t iclass;
    rdag_rsel_t dst;
    rdag_rsel_t src;
    logic [3:0] base;
    rdag_imm_t imm_kind;
    logic [31:0] imm;
    logic [31:0] pc;
    rdag_amode_t amode;
    rdag_width_t width;
    logic mem_signed;
    logic mem_write;
    logic ovf_check;
    logic carry_use;
    logic trap;
    logic exc_return;
    logic reserved;
  } rdag_dec_t;

  typedef struct packed {
    logic valid;
    logic mem_access;
    logic [31:0] addr;
    logic wb_en;
    logic [3:0] wb_idx;
    logic [31:0] wb_data;
  } rdag_agen_t;

endpackage

// ### logic/rdag_addr_gen.sv
// Forms the effective address one cycle after a decode, from the decoded
// fields and the base register contents that the register file returns.
module rdag_addr_gen import rdag_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input rdag_dec_t dec,
  input wire logic [31:0] base_data,
  output rdag_agen_t agen
);
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    rdag_agen_t agen;
  } rdag_ag_state_t;

  rdag_ag_state_t st;
  rdag_ag_state_t next_st;

  // Address arithmetic per mode; reserved slots produce no access.
  always_comb begin
    next_st = '0;
    next_st.agen.valid = dec.valid;
    next_st.agen.wb_idx = dec.base;
    if (dec.valid && !dec.reserved) begin
      next_st.agen.mem_access = dec.iclass == RDAG_CL_LOADSTORE;
      case (dec.amode)
        RDAG_AM_INDIRECT: begin
          next_st.agen.addr = base_data;
        end
        RDAG_AM_RELATIVE: begin
          next_st.agen.addr = base_data + dec.imm;
        end
        RDAG_AM_POSTINC: begin
          // The access uses the old value; the register moves on afterwards.
          next_st.agen.addr = base_data;
          next_st.agen.wb_en = 1'b1;
          next_st.agen.wb_data = base_data + UPDATE_STEP;
        end
        RDAG_AM_PREINC: begin
          next_st.agen.addr = base_data + UPDATE_STEP;
          next_st.agen.wb_en = 1'b1;
          next_st.agen.wb_data = base_data + UPDATE_STEP;
        end
        RDAG_AM_PREDEC: begin
          next_st.agen.addr = base_data - UPDATE_STEP;
          next_st.agen.wb_en = 1'b1;
          next_st.agen.wb_data = base_data - UPDATE_STEP;
        end
        RDAG_AM_PCREL: begin
          // The displacement counts words, so it is scaled before the add.
          next_st.agen.addr = dec.pc + (dec.imm << PCREL_SHIFT);
        end
        default: begin
          next_st.agen.addr = '0;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign agen = st.agen;

endmodule

// ### dv/rdag_decoder_sva.sv
module rdag_decoder_chk import rdag_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [31:0] fetch_word,
  input wire logic [31:0] fetch_pc,
  input wire logic fetch_valid,
  input wire logic fetch_ready,
  input wire logic [31:0] base_data,
  input rdag_dec_t dec,
  input rdag_agen_t agen
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic take;
  // A word is taken only on an edge where both handshake sides are high.
  assign take = fetch_valid && fetch_ready;

  word_slot_a: assert property (take && fetch_word[31] |=>
    !fetch_ready ##1 (dec.valid && fetch_ready) ##1 !dec.valid)
    else $error("single word slot timing wrong");
  pair_slot_a: assert property (take && !fetch_word[31] |=>
    !fetch_ready ##1 (dec.valid && !fetch_ready) ##1 (dec.valid && fetch_ready))
    else $error("packed pair slot timing wrong");
  agen_follow_a: assert property (dec.valid |=> agen.valid)
    else $error("address result missing after decode");
  indirect_addr_a: assert property (dec.valid && dec.amode == RDAG_AM_INDIRECT |=>
    agen.mem_access && agen.addr == $past(base_data))
    else $error("indirect address differs from base");
  relative_addr_a: assert property (dec.valid && dec.amode == RDAG_AM_RELATIVE |=>
    agen.addr == $past(base_data) + $past(dec.imm))
    else $error("relative address wrong");
  postinc_load_a: assert property (dec.valid && dec.amode == RDAG_AM_POSTINC |=>
    agen.addr == $past(base_data) && agen.wb_en && agen.wb_data == agen.addr + UPDATE_STEP)
    else $error("post-increment load wrong");
  preinc_store_a: assert property (dec.valid && dec.amode == RDAG_AM_PREINC |=>
    agen.addr == $past(base_data) + UPDATE_STEP && agen.wb_en && agen.wb_data == agen.addr)
    else $error("pre-increment store wrong");
  predec_store_a: assert property (dec.valid && dec.amode == RDAG_AM_PREDEC |=>
    agen.addr == $past(base_data) - UPDATE_STEP && agen.wb_en && agen.wb_data == agen.addr)
    else $error("pre-decrement store wrong");
  pcrel_addr_a: assert property (dec.valid && dec.amode == RDAG_AM_PCREL |=>
    agen.addr == $past(dec.pc) + ($past(dec.imm) << PCREL_SHIFT))
    else $error("pc relative target wrong");
  reserved_quiet_a: assert property (dec.valid && dec.reserved |=>
    agen.valid && !agen.mem_access && !agen.wb_en)
    else $error("reserved slot touched memory");
  op_range_a: assert property (dec.valid && !dec.reserved |-> dec.op < OP_COUNT)
    else $error("accepted opcode out of range");
  exc_class_a: assert property (dec.valid && (dec.trap || dec.exc_return) |->
    dec.iclass == RDAG_CL_EXC)
    else $error("trap or return outside exception class");

  // The main traffic shapes the bench is expected to reach.
  cover property (take && !fetch_word[31]);
  cover property (dec.valid && dec.reserved);
  cover property (dec.valid && dec.amode == RDAG_AM_PCREL);
endmodule

bind rdag_decoder rdag_decoder_chk chk_u (.clk(clk), .rst_b(rst_b), .fetch_word(fetch_word),
  .fetch_pc(fetch_pc), .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
  .base_data(base_data), .dec(dec), .agen(agen));

// ### dv/risc_decode_and_address_gen_tb_top.sv
module risc_decode_and_address_gen_tb_top import rdag_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, fetch_valid, fetch_ready;
  logic [31:0] fetch_word, fetch_pc, base_data, b, pcw;
  logic [31:0] regs [16];
  logic [3:0] ra, rb, rb2;
  logic [23:0] d24;
  logic [7:0] d8, d8b;
  rdag_dec_t dec, d;
  rdag_agen_t agen, a;
  rdag_dec_t dq[$];
  rdag_agen_t aq[$];
  logic [31:0] bq[$];
  int miscompares, checked, cnt;
  rdag_width_t wtab [10] = '{RDAG_W_WORD, RDAG_W_BYTE, RDAG_W_BYTE, RDAG_W_HALF, RDAG_W_HALF,
    RDAG_W_WORD, RDAG_W_WORD, RDAG_W_BYTE, RDAG_W_HALF, RDAG_W_WORD};
  logic [6:0] fop [6] = '{OP_ADD_OVF, OP_SUB_OVF, OP_ADD_CARRY, OP_SUB_BORROW, OP_EXC_RETURN,
    OP_ACCUM_ROUND};
  logic [2:0] fx [6] = '{3'h4, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
  rdag_class_t fcl [6] = '{RDAG_CL_ARITH, RDAG_CL_ARITH, RDAG_CL_ARITH, RDAG_CL_ARITH,
    RDAG_CL_EXC, RDAG_CL_DSP};

  // The register file answers in the same cycle, so it is modelled combinationally.
  assign base_data = regs[dec.base];

  rdag_decoder dut_u (.clk(clk), .rst_b(rst_b), .fetch_word(fetch_word), .fetch_pc(fetch_pc),
    .fetch_valid(fetch_valid), .fetch_ready(fetch_ready), .base_data(base_data), .dec(dec),
    .agen(agen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Results are collected on the falling edge, well clear of the launching edge.
  always @(negedge clk) begin
    if (dec.valid === 1'b1) begin
      dq.push_back(dec);
      bq.push_back(base_data);
    end
    if (agen.valid === 1'b1) aq.push_back(agen);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("counts: checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Waits for ready, offers one word for exactly one taking edge, then lets all slots drain.
  task automatic issue(input logic [31:0] w);
    int n;
    n = 0;
    while (fetch_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    fetch_word = w;
    fetch_pc = $urandom;
    pcw = fetch_pc & 32'hFFFF_FFFC;
    fetch_valid = 1'b1;
    @(posedge clk);
    #1;
    fetch_valid = 1'b0;
    fetch_word = ~w;
    repeat (5) @(posedge clk);
    #1;
  endtask

  task automatic pop();
    chk(dq.size() > 0 && aq.size() > 0, 32'h1);
    if (dq.size() > 0 && aq.size() > 0) begin
      d = dq.pop_front();
      a = aq.pop_front();
      b = bq.pop_front();
    end
  endtask

  task automatic done(input string s);
    chk(dq.size() + aq.size(), 32'h0);
    $display("test %s finished", s);
  endtask

  task automatic ls_chk(input int op, input logic [3:0] r);
    pop();
    chk(d.op, op);
    chk(d.iclass, RDAG_CL_LOADSTORE);
    chk(d.width, wtab[op]);
    if (op >= 1 && op <= 4) chk(d.mem_signed, op[0]);
    chk(d.mem_write, op >= 6);
    chk(a.addr, regs[r]);
    chk(d.base, r);
    chk(b, regs[r]);
  endtask

  initial begin
    rst_b = 1'b0;
    fetch_valid = 1'b0;
    fetch_word = 32'h0000_0000;
    fetch_pc = 32'h0000_0000;
    void'($urandom(47));
    for (int i = 0; i < 16; i++) regs[i] = $urandom;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    // Packed pairs of every load and store, high half first.
    for (int k = 0; k < 10; k += 2) begin
      ra = 4'($urandom);
      rb = 4'($urandom);
      rb2 = 4'($urandom);
      issue({1'b0, 7'(k), ra, rb, 1'b0, 7'(k + 1), ra, rb2});
      ls_chk(k, rb);
      ls_chk(k + 1, rb2);
    end
    done("load_store");
    for (int k = 0; k < 2; k++) begin
      d24 = 24'($urandom);
      issue({1'b1, k ? OP_STORE_WORD : OP_LOAD_WORD, d24});
      pop();
      chk(a.addr, regs[d24[19:16]] + {{16{d24[15]}}, d24[15:0]});
      chk(d.imm_kind, RDAG_IMM16);
    end
    done("relative");
    issue({1'b0, OP_LOAD_POSTINC, ra, rb, 1'b0, OP_STORE_PREINC, ra, rb2});
    pop();
    chk(a.addr, regs[rb]);
    chk(a.wb_en, 32'h1);
    chk(a.wb_data, regs[rb] + 32'h0000_0004);
    chk(a.wb_idx, rb);
    pop();
    chk({a.mem_access, d.mem_write}, 32'h3);
    chk(a.addr, regs[rb2] + 32'h0000_0004);
    chk(a.wb_data, regs[rb2] + 32'h0000_0004);
    issue({1'b0, OP_STORE_PREDEC, ra, rb, 16'h0000});
    pop();
    chk(a.addr, regs[rb] - 32'h0000_0004);
    chk(a.wb_data, regs[rb] - 32'h0000_0004);
    pop();
    done("update");
    d8 = 8'($urandom);
    d8b = 8'($urandom);
    issue({1'b0, OP_BR_CARRY, d8, 1'b0, OP_BR_NCARRY, d8b});
    pop();
    chk(a.addr, pcw + ({{24{d8[7]}}, d8} << 2));
    chk(d.imm_kind, RDAG_IMM8);
    pop();
    chk(a.addr, pcw + ({{24{d8b[7]}}, d8b} << 2));
    d24 = 24'($urandom);
    issue({1'b1, OP_BR_ALWAYS, d24});
    pop();
    chk(a.addr, pcw + ({{8{d24[23]}}, d24} << 2));
    chk(d.imm_kind, RDAG_IMM24);
    done("pc_relative");
    // Every opcode in the long form: exactly the implemented set decodes.
    cnt = 0;
    for (int k = 0; k < 128; k++) begin
      issue({1'b1, 7'(k), 24'($urandom)});
      pop();
      chk(d.reserved, k >= 83);
      if (d.reserved === 1'b0) cnt++;
      else chk(a.mem_access | a.wb_en, 32'h0);
      if (k >= 68 && k < 83) chk(d.iclass, RDAG_CL_DSP);
    end
    chk(cnt, 83);
    issue({1'b0, OP_ADD3, 8'h12, 1'b1, OP_LOAD_WORD, 8'h34});
    pop();
    chk(d.reserved, 32'h1);
    pop();
    chk({d.reserved, a.mem_access}, 32'h2);
    done("opcode_sweep");
    for (int i = 0; i < 6; i++) begin
      issue({1'b1, fop[i], 24'h00_0000});
      pop();
      chk({d.ovf_check, d.carry_use, d.exc_return}, fx[i]);
      chk(d.iclass, fcl[i]);
    end
    issue({1'b0, OP_TRAP, ra, rb, 1'b0, OP_ADD_IMM, ra, rb});
    pop();
    chk({d.trap, d.imm_kind}, {1'b1, RDAG_IMM4});
    chk(d.imm, {28'h0000000, rb});
    pop();
    chk(d.imm_kind, RDAG_IMM8);
    issue({1'b0, OP_MOVE_FROM_CTRL, ra, rb, 1'b0, OP_LOAD_IMM, ra, rb});
    pop();
    chk(d.src, {1'b1, rb});
    chk(a.mem_access, 32'h0);
    pop();
    chk({d.iclass, a.mem_access}, {RDAG_CL_TRANSFER, 1'b0});
    chk(d.imm, {{24{ra[3]}}, ra, rb});
    issue({1'b1, OP_LOAD_IMM24, d24});
    pop();
    chk(d.imm, {8'h00, d24});
    issue({1'b1, OP_SHL_IMM, ra, rb, 16'h0000});
    pop();
    chk(d.imm_kind, RDAG_IMM5);
    // Control-register destination, then the rarer immediate shapes.
    issue({1'b0, OP_MOVE_TO_CTRL, ra, rb, 1'b0, OP_NO_OP, 8'h00});
    pop();
    chk(d.dst, {1'b1, ra});
    pop();
    issue({1'b1, OP_SET_HIGH, ra, rb, 16'h8001});
    pop();
    chk(d.imm, 32'h8001_0000);
    issue({1'b1, OP_AND3, ra, rb, 16'h8000});
    pop();
    chk(d.imm, 32'h0000_8000);
    // A 32-bit branch that is not one of the long forms takes a 16-bit displacement.
    issue({1'b1, 7'(OP_BRANCH_BASE + 7'h01), 8'h00, 16'hFFFF});
    pop();
    chk(d.imm_kind, RDAG_IMM16);
    chk(a.addr, pcw - 32'h0000_0004);
    done("flags_and_immediates");
    tally_and_finish();
  end

  // The whole run needs under a thousand cycles; this bound only cuts a hang short.
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule
